// File: design/dasout_top.v
// dual-channel serial result port: strap-selected one or two output lines
`timescale 1ns/10ps
`include "dasout_map.vh"

module dasout_top #(
  parameter DATA_BITS = `DASOUT_DATA_BITS,
  parameter FIFO_DEPTH = `DASOUT_FIFO_DEPTH,
  parameter FIFO_ADDR_W = `DASOUT_FIFO_ADDR_W
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst,
  // pins from the host
  input  wire                 sclk,
  input  wire                 cs_n,
  input  wire                 dual_mode,
  // serial output lines
  output reg                  serial_out_first,
  output reg                  serial_out_first_oe,
  output reg                  serial_out_second,
  output reg                  serial_out_second_oe,
  // conversion results from the sampling core
  input  wire                 sample_valid,
  output wire                 sample_ready,
  input  wire [DATA_BITS-1:0] sample_a,
  input  wire [DATA_BITS-1:0] sample_b,
  // status
  output reg                  power_down,
  output reg                  conv_start,
  output reg                  conv_underrun,
  output reg                  frame_done
);

  // --------------------------------------------------------------------
  // local constants
  // --------------------------------------------------------------------
  localparam WORD_BITS = `DASOUT_NULL_BITS + DATA_BITS;
  localparam PAIR_BITS = 2 * DATA_BITS;
  // one register holds both words; in dual mode its low half stays unused
  localparam SHIFT_BITS = 2 * WORD_BITS;

  localparam [1:0] ST_POWER_DOWN = 2'h0;
  localparam [1:0] ST_SHIFT      = 2'h1;
  localparam [1:0] ST_DONE       = 2'h2;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  reg sclk_q1;
  reg sclk_q2;
  reg sclk_q3;
  reg cs_q1;
  reg cs_q2;
  reg cs_q3;
  reg dual_q1;
  reg dual_q2;

  // only the second and third stages feed logic
  // sclk high and low must each last over one clk period, or an edge is lost
  // a false fall after reset with sclk idling low is ignored while powered down
  always @(posedge clk) begin
    if (rst) begin
      sclk_q1 <= `DASOUT_RST_SYNC;
      sclk_q2 <= `DASOUT_RST_SYNC;
      sclk_q3 <= `DASOUT_RST_SYNC;
    end else begin
      sclk_q1 <= sclk;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
    end
  end

  // select resets high, its idle level, so leaving reset with select high shows no edge
  always @(posedge clk) begin
    if (rst) begin
      cs_q1 <= `DASOUT_RST_SYNC;
      cs_q2 <= `DASOUT_RST_SYNC;
      cs_q3 <= `DASOUT_RST_SYNC;
    end else begin
      cs_q1 <= cs_n;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
    end
  end

  // the strap is static; it is read only when a frame loads
  always @(posedge clk) begin
    if (rst) begin
      dual_q1 <= `DASOUT_RST_SYNC;
      dual_q2 <= `DASOUT_RST_SYNC;
    end else begin
      dual_q1 <= dual_mode;
      dual_q2 <= dual_q1;
    end
  end

  // the serial clock is the only pacing source for the frame
  wire sclk_fall = sclk_q3 & ~sclk_q2;
  wire cs_fall   = cs_q3 & ~cs_q2;
  wire cs_rise   = ~cs_q3 & cs_q2;

  // --------------------------------------------------------------------
  // result buffer
  // --------------------------------------------------------------------
  wire                 fifo_valid;
  wire [PAIR_BITS-1:0] fifo_data;
  // the sampling core pushes pairs; each loaded frame pops one if the buffer holds any
  wire                 fifo_pop;

  dasout_fifo #(
    .WIDTH  (PAIR_BITS),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_ADDR_W)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({sample_a, sample_b}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // --------------------------------------------------------------------
  // frame helpers
  // --------------------------------------------------------------------
  function [WORD_BITS-1:0] make_word;
    input [DATA_BITS-1:0] result;
    begin
      make_word = {`DASOUT_NULL_VALUE, result};
    end
  endfunction

  function [5:0] frame_len;
    input dual;
    begin
      if (dual)
        frame_len = `DASOUT_LEN_DUAL;
      else
        frame_len = `DASOUT_LEN_SINGLE;
    end
  endfunction

  // an empty buffer still gives a full frame, but of zeros
  wire [DATA_BITS-1:0] res_a = fifo_valid ? fifo_data[PAIR_BITS-1:DATA_BITS] : {DATA_BITS{1'b0}};
  wire [DATA_BITS-1:0] res_b = fifo_valid ? fifo_data[DATA_BITS-1:0] : {DATA_BITS{1'b0}};
  wire [WORD_BITS-1:0] word_a = make_word(res_a);
  wire [WORD_BITS-1:0] word_b = make_word(res_b);

  // --------------------------------------------------------------------
  // frame state
  // --------------------------------------------------------------------
  reg [1:0]            state;
  reg [1:0]            next_state;
  reg                  dual_latched;
  reg [5:0]            bit_idx;
  reg [SHIFT_BITS-1:0] shift_first;
  reg [WORD_BITS-1:0]  shift_second;

  // frame end is the last falling edge of the strap-chosen length
  wire [5:0] last_idx = frame_len(dual_latched) - 6'h01;
  wire       last_bit = (bit_idx == last_idx);

  // a pair leaves the buffer only when a frame really loads it
  wire load_frame = (state == ST_POWER_DOWN) && cs_fall;
  assign fifo_pop = load_frame;

  always @* begin
    next_state = state;
    case (state)
      ST_POWER_DOWN: begin
        if (cs_fall)
          next_state = ST_SHIFT;
      end
      ST_SHIFT: begin
        // select rising mid-frame aborts; undelivered bits are dropped
        if (cs_rise)
          next_state = ST_POWER_DOWN;
        else if (sclk_fall && last_bit)
          next_state = ST_DONE;
      end
      ST_DONE: begin
        if (cs_rise)
          next_state = ST_POWER_DOWN;
      end
      default: next_state = ST_POWER_DOWN;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_POWER_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // shift path
  // --------------------------------------------------------------------
  // strap is taken once per frame so a mid-frame change cannot tear it
  // bit_idx counts the falling edges seen in this frame
  always @(posedge clk) begin
    if (rst) begin
      dual_latched <= 1'b1;
      bit_idx      <= 6'h00;
      shift_first  <= {SHIFT_BITS{1'b0}};
      shift_second <= {WORD_BITS{1'b0}};
    end else if (load_frame) begin
      dual_latched <= dual_q2;
      bit_idx      <= 6'h00;
      if (dual_q2) begin
        shift_first  <= {word_a, {WORD_BITS{1'b0}}};
        shift_second <= word_b;
      end else begin
        shift_first  <= {word_a, word_b};
        shift_second <= {WORD_BITS{1'b0}};
      end
    end else if (state == ST_SHIFT && sclk_fall) begin
      bit_idx      <= bit_idx + 6'h01;
      shift_first  <= {shift_first[SHIFT_BITS-2:0], 1'b0};
      shift_second <= {shift_second[WORD_BITS-2:0], 1'b0};
    end
  end

  // --------------------------------------------------------------------
  // output lines
  // --------------------------------------------------------------------
  // a cut frame releases the lines at once; the pair it carried is lost
  always @(posedge clk) begin
    if (rst) begin
      serial_out_first     <= `DASOUT_RST_LINE;
      serial_out_second    <= `DASOUT_RST_LINE;
      serial_out_first_oe  <= `DASOUT_RST_OE;
      serial_out_second_oe <= `DASOUT_RST_OE;
    end else begin
      case (next_state)
        ST_SHIFT: begin
          serial_out_first_oe  <= 1'b1;
          // until the frame latches the strap, the live strap sets the second enable
          serial_out_second_oe <= (state == ST_SHIFT) ? dual_latched : dual_q2;
          if (state == ST_POWER_DOWN) begin
            // first null bit appears as soon as select falls
            serial_out_first  <= word_a[WORD_BITS-1];
            serial_out_second <= dual_q2 ? word_b[WORD_BITS-1] : 1'b0;
          end else if (sclk_fall) begin
            serial_out_first  <= shift_first[SHIFT_BITS-2];
            serial_out_second <= dual_latched ? shift_second[WORD_BITS-2] : 1'b0;
          end
        end
        ST_DONE: begin
          // frame spent: keep driving low until select rises
          serial_out_first     <= 1'b0;
          serial_out_second    <= 1'b0;
          serial_out_first_oe  <= 1'b1;
          serial_out_second_oe <= dual_latched;
        end
        default: begin
          // power-down releases both lines
          serial_out_first     <= 1'b0;
          serial_out_second    <= 1'b0;
          serial_out_first_oe  <= 1'b0;
          serial_out_second_oe <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // status
  // --------------------------------------------------------------------
  // levels follow the next state so they move with the line enables
  always @(posedge clk) begin
    if (rst) begin
      power_down <= 1'b1;
      frame_done <= 1'b0;
    end else begin
      power_down <= (next_state == ST_POWER_DOWN);
      frame_done <= (next_state == ST_DONE);
    end
  end

  // one-cycle pulses; an underrun frame still runs, but carries zeros
  always @(posedge clk) begin
    if (rst) begin
      conv_start    <= 1'b0;
      conv_underrun <= 1'b0;
    end else begin
      conv_start    <= load_frame;
      conv_underrun <= load_frame && !fifo_valid;
    end
  end

endmodule // dasout_top

// File: design/dasout_map.vh
// constants for the dual-channel serial result port
`ifndef DASOUT_MAP_VH
`define DASOUT_MAP_VH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define DASOUT_NULL_BITS    4
`define DASOUT_DATA_BITS    12
`define DASOUT_WORD_BITS    16
`define DASOUT_NULL_VALUE   4'h0

// ----------------------------------------------------------------------
// frame lengths in serial clock falling edges
// ----------------------------------------------------------------------
`define DASOUT_LEN_DUAL     6'h10
`define DASOUT_LEN_SINGLE   6'h20

// ----------------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------------
`define DASOUT_FIFO_DEPTH   32
`define DASOUT_FIFO_ADDR_W  5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DASOUT_RST_LINE     1'b0
`define DASOUT_RST_OE       1'b0
`define DASOUT_RST_SYNC     1'b1

`endif

// File: design/dasout_fifo.v
// result buffer: synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps

module dasout_fifo #(
  parameter WIDTH  = 24,
  parameter DEPTH  = 32,
  parameter ADDR_W = 5
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  // --------------------------------------------------------------------
  // storage and pointers
  // --------------------------------------------------------------------
  reg [WIDTH-1:0]  mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr;
  reg [ADDR_W-1:0] rd_ptr;
  reg [ADDR_W:0]   count;
  reg [ADDR_W:0]   next_count;

  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;

  localparam [ADDR_W:0] DEPTH_W = DEPTH[ADDR_W:0];

  function [ADDR_W-1:0] ptr_inc;
    input [ADDR_W-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_inc = {ADDR_W{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  assign out_data = mem[rd_ptr];

  always @* begin
    next_count = count;
    case ({do_wr, do_rd})
      2'b10:   next_count = count + 1'b1;
      2'b01:   next_count = count - 1'b1;
      default: next_count = count;
    endcase
  end

  // --------------------------------------------------------------------
  // flags are registered so the fill-side ready leaves from a flop
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr    <= {ADDR_W{1'b0}};
      rd_ptr    <= {ADDR_W{1'b0}};
      count     <= {(ADDR_W+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count     <= next_count;
      in_ready  <= (next_count != DEPTH_W);
      out_valid <= (next_count != {(ADDR_W+1){1'b0}});
    end
  end

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // dasout_fifo

// File: bench/dasout_top_asserts.sv
// concurrent checks on the serial result port pins
`timescale 1ns/10ps
module dasout_top_asserts (
  // clock and reset
  input wire clk,
  input wire rst,
  // host pins
  input wire sclk,
  input wire cs_n,
  input wire dual_mode,
  // lines and status
  input wire serial_out_first,
  input wire serial_out_first_oe,
  input wire serial_out_second,
  input wire serial_out_second_oe,
  input wire power_down,
  input wire conv_start,
  input wire conv_underrun,
  input wire frame_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // helper: clocks since the last serial clock fall, saturating
  // ----------------------------------------------------------------------
  reg [3:0] sclk_age;
  always @(posedge clk) begin
    if (rst)
      sclk_age <= 4'hf;
    else if ($fell(sclk))
      sclk_age <= 4'h0;
    else if (sclk_age != 4'hf)
      sclk_age <= sclk_age + 4'h1;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  sequence s_sel_fall;
    $fell(cs_n);
  endsequence
  sequence s_started;
    ##[2:6] conv_start;
  endsequence
  property p_start;
    s_sel_fall |-> s_started;
  endproperty
  a_sel_fall_start: assert property (p_start) else $error("no start after select fall");
  a_start_drives: assert property (conv_start |-> serial_out_first_oe && !power_down)
    else $error("first line not driven at start");
  a_first_null: assert property (conv_start |-> !serial_out_first && !serial_out_second)
    else $error("first bit not null");
  a_dual_second: assert property (conv_start && dual_mode |-> serial_out_second_oe)
    else $error("second line not driven in dual mode");
  a_single_float: assert property (conv_start && !dual_mode |-> !serial_out_second_oe [*8])
    else $error("second line driven in single mode");
  // a bit may only move a few clocks after a serial clock fall
  a_bit_on_fall: assert property ($changed(serial_out_first) && serial_out_first_oe &&
    $past(serial_out_first_oe) && !conv_start |-> sclk_age inside {[1:6]})
    else $error("bit changed away from a clock fall");
  a_pd_released: assert property (power_down |-> !serial_out_first_oe && !serial_out_second_oe)
    else $error("line driven in power down");
  a_cs_high_pd: assert property (cs_n [*6] |=> power_down) else $error("no power down");
  a_underrun_start: assert property (conv_underrun |-> conv_start) else $error("stray underrun");
  a_done_quiet: assert property (frame_done |-> !serial_out_first && !power_down)
    else $error("line not low after frame");
endmodule // dasout_top_asserts

bind dasout_top dasout_top_asserts chk_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .dual_mode(dual_mode), .serial_out_first(serial_out_first), .serial_out_first_oe(serial_out_first_oe),
  .serial_out_second(serial_out_second), .serial_out_second_oe(serial_out_second_oe),
  .power_down(power_down), .conv_start(conv_start), .conv_underrun(conv_underrun), .frame_done(frame_done));

// File: bench/dasout_host.sv
// host model: drives serial clock and select, samples both lines
`timescale 1ns/10ps
module dasout_host (
  // pins to the port
  output reg  sclk,
  output reg  cs_n,
  // lines from the port
  input  wire d1,
  input  wire d1_oe,
  input  wire d2,
  input  wire d2_oe
);
  reg [31:0] cap1;
  reg [15:0] cap2;
  reg        oe2_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // released lines read as unknown, so a capture of them never matches
  task frame(input integer n);
    integer i;
    begin
      cap1 = 32'h0;
      cap2 = 16'h0;
      oe2_seen = 1'b0;
      cs_n = 1'b0;
      #40;
      for (i = 0; i < n; i = i + 1) begin
        sclk = 1'b1;
        cap1 = {cap1[30:0], d1_oe ? d1 : 1'bx};
        cap2 = {cap2[14:0], d2_oe ? d2 : 1'bx};
        oe2_seen = oe2_seen | d2_oe;
        #24;
        sclk = 1'b0;
        #24;
      end
      cs_n = 1'b1;
      #40;
    end
  endtask
endmodule // dasout_host

// File: bench/dasout_top_test.sv
// self-checking bench for the dual-channel serial result port
`timescale 1ns/10ps
module dasout_top_test;
  reg         clk;
  reg         rst;
  reg         dual_mode;
  reg         sample_valid;
  reg  [11:0] sample_a;
  reg  [11:0] sample_b;
  reg         done_prev;
  wire        sclk;
  wire        cs_n;
  wire        serial_out_first;
  wire        serial_out_first_oe;
  wire        serial_out_second;
  wire        serial_out_second_oe;
  wire        sample_ready;
  wire        power_down;
  wire        conv_start;
  wire        conv_underrun;
  wire        frame_done;
  integer     bad_count;
  integer     checks;
  integer     urun_count;
  integer     start_count;
  integer     done_count;

  dasout_top dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dual_mode(dual_mode),
    .serial_out_first(serial_out_first), .serial_out_first_oe(serial_out_first_oe),
    .serial_out_second(serial_out_second), .serial_out_second_oe(serial_out_second_oe),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_a(sample_a), .sample_b(sample_b),
    .power_down(power_down), .conv_start(conv_start), .conv_underrun(conv_underrun), .frame_done(frame_done));
  dasout_host host_u (.sclk(sclk), .cs_n(cs_n), .d1(serial_out_first), .d1_oe(serial_out_first_oe),
    .d2(serial_out_second), .d2_oe(serial_out_second_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // status events counted where the outputs are settled
  always @(negedge clk) begin
    if (rst) begin
      urun_count  <= 0;
      start_count <= 0;
      done_count  <= 0;
      done_prev   <= 1'b0;
    end else begin
      done_prev <= frame_done;
      if (conv_underrun === 1'b1)
        urun_count <= urun_count + 1;
      if (conv_start === 1'b1)
        start_count <= start_count + 1;
      if (frame_done === 1'b1 && done_prev !== 1'b1)
        done_count <= done_count + 1;
    end
  end

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // offer pairs for 40 clocks with no host activity, past the point where the buffer refuses
  task fill_refuse;
    integer n;
    integer i;
    begin
      n = 0;
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge clk);
        sample_valid = 1'b1;
        sample_a = {7'h55, n[4:0]};
        sample_b = {n[4:0], 7'h2a};
        if (sample_ready === 1'b1)
          n = n + 1;
      end
      @(negedge clk);
      sample_valid = 1'b0;
      chk("accepted pairs", 32'd32, n);
      chk("ready when full", 32'h0, {31'h0, sample_ready});
    end
  endtask

  // oldest pair first, then an empty frame of zeros
  task drain_dual;
    integer j;
    begin
      for (j = 0; j < 32; j = j + 1) begin
        host_u.frame(16);
        chk("line one word", {20'h0, 7'h55, j[4:0]}, host_u.cap1);
        chk("line two word", {20'h0, j[4:0], 7'h2a}, {16'h0, host_u.cap2});
      end
      host_u.frame(16);
      chk("empty frame", 32'h0, host_u.cap1);
      chk("underrun count", 32'h1, urun_count);
      chk("frames started", 32'd33, start_count);
      chk("frames done", 32'd33, done_count);
      chk("power down", 32'h1, {31'h0, power_down});
      chk("lines released", 32'h0, {30'h0, serial_out_first_oe, serial_out_second_oe});
    end
  endtask

  task single_line;
    begin
      @(negedge clk);
      dual_mode = 1'b0;
      sample_valid = 1'b1;
      sample_a = 12'hf0f;
      sample_b = 12'h0f1;
      @(negedge clk);
      sample_valid = 1'b0;
      repeat (8) @(negedge clk);
      host_u.frame(32);
      chk("shared word", {4'h0, 12'hf0f, 4'h0, 12'h0f1}, host_u.cap1);
      chk("single frame done", 32'd34, done_count);
      chk("no underrun in single", 32'h1, urun_count);
      chk("second line driven", 32'h0, {31'h0, host_u.oe2_seen});
    end
  endtask

  initial begin
    rst = 1'b1;
    dual_mode = 1'b1;
    sample_valid = 1'b0;
    sample_a = 12'h000;
    sample_b = 12'h000;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    fill_refuse;
    drain_dual;
    single_line;
    tally_and_finish;
  end
endmodule // dasout_top_test
